// ### src/pairing_ctrl_pkg.sv
// Constants, encodings and timing counts for the pairing and link control.
// Assumes a single 10 MHz clock and an AXI4-Lite register bus.
//
// Behaviour
// - When the radio link comes up, the connect-detect pin goes low.
// - When the radio link goes down, the connect-detect pin returns high.
// - A reset-pin low held for at least one second restores factory defaults.
// - Pairing and reset pins are active low; pairing is on the big variant.
// - A two-second pairing low moves the unit to open acceptor mode.
// - From idle, first low gives open acceptor, second reconnect initiator.
// - After pin pairing, open acceptor acts as slave and initiator as master.
// - Connection after pin pairing may take about ten seconds or more.
// - Response messages are suppressed while pin-driven pairing runs.
// - Responses are exactly OK, ERROR, CONNECT and DISCONNECT; the block never sends ERROR.
// - Four modes: idle command, reconnect initiator/acceptor, open acceptor.
// - The unit reports standby, pending or connect as its state.
// - A factory restore sets every stored parameter, mode too, to default; irq_mask_ff keeps its value and the IRQ status gains its factory bit.
// - The host may switch command responses on or off.
package pairing_ctrl_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RESET_HOLD_MS = 1000;
  localparam int unsigned PAIR_HOLD_MS = 2000;
  localparam int unsigned CONNECT_WAIT_MS = 10000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned PAIR_HOLD_CYC = PAIR_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned CONNECT_WAIT_CYC = CONNECT_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 27;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam int unsigned CTRL_LINK_UP = 0;
  localparam int unsigned CTRL_RESP_EN = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_RESP_REQ = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FACTORY = 0;
  localparam int unsigned IRQ_MODE = 1;
  localparam int unsigned IRQ_LINK = 2;
  localparam int unsigned IRQ_TIMEOUT = 3;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    idle_command_mode, reconnect_initiator_mode,
    reconnect_acceptor_mode, open_acceptor_mode
  } op_mode_e;
  typedef enum logic [1:0] {st_standby, st_pending, st_connect} op_state_e;
  typedef enum logic [1:0] {rsp_ok, rsp_error, rsp_connect, rsp_disconnect}
    rsp_msg_e;
  typedef enum logic [2:0] {
    pr_idle, pr_low1, pr_high1, pr_low2, pr_wait
  } pair_st_e;
  localparam logic [1:0] MODE_RST = 2'h0;

endpackage : pairing_ctrl_pkg

// ### src/pairing_ctrl.sv
// Pairing pin, factory reset pin and connect-detect control with registers.
// Assumes asynchronous pin inputs and an AXI4-Lite master on clk.
module pairing_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins
  input wire logic pair_req_n,
  input wire logic factory_rst_n,
  output logic link_detect_n,
  // Status outputs
  output logic [1:0] op_mode,
  output logic [1:0] op_state,
  output logic link_master,
  output logic resp_valid,
  output logic [1:0] resp_msg,
  output logic factory_pulse,
  output logic irq,
  // AXI4-Lite
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [1:0] pair_sync_ff;
  logic [1:0] frst_sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pair_sync_ff <= 2'b11;
      frst_sync_ff <= 2'b11;
    end else begin
      pair_sync_ff <= {pair_sync_ff[0], pair_req_n};
      frst_sync_ff <= {frst_sync_ff[0], factory_rst_n};
    end
  end
  wire pair_low = !pair_sync_ff[1];
  wire frst_low = !frst_sync_ff[1];

  // ***************************************************************
  // Factory reset timing
  // ***************************************************************
  // A low shorter than the hold never fires; the counter restarts on any
  // high, which is the debounce. One pulse per press, however long.
  logic [pairing_ctrl_pkg::CNT_W-1:0] frst_cnt_ff;
  logic frst_done_ff;
  wire frst_hit = frst_low && !frst_done_ff &&
    (frst_cnt_ff == pairing_ctrl_pkg::CNT_W'(
      pairing_ctrl_pkg::RESET_HOLD_CYC - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frst_cnt_ff <= '0;
      frst_done_ff <= 1'b0;
    end else if (!frst_low) begin
      frst_cnt_ff <= '0;
      frst_done_ff <= 1'b0;
    end else begin
      if (!frst_done_ff) frst_cnt_ff <= frst_cnt_ff + 1'b1;
      if (frst_hit) frst_done_ff <= 1'b1;
    end
  end

  // ***************************************************************
  // Pairing sequence timing
  // ***************************************************************
  pairing_ctrl_pkg::pair_st_e pst_ff;
  pairing_ctrl_pkg::pair_st_e nxt_pst;
  logic [pairing_ctrl_pkg::CNT_W-1:0] pcnt_ff;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic link_ff;
  logic link_up_ff;
  logic resp_en_ff;
  logic pairing_ff;
  logic nxt_pairing;
  logic master_ff;
  logic nxt_master;
  logic timeout_ev;
  wire [1:0] sw_mode;
  wire sw_mode_wr;
  wire pair_hold = pcnt_ff >= pairing_ctrl_pkg::CNT_W'(
    pairing_ctrl_pkg::PAIR_HOLD_CYC - 1);
  wire wait_over = pcnt_ff >= pairing_ctrl_pkg::CNT_W'(
    pairing_ctrl_pkg::CONNECT_WAIT_CYC - 1);
  wire level_now = (pst_ff == pairing_ctrl_pkg::pr_high1) ? !pair_low :
    pair_low;
  wire restart_cnt = (pst_ff != nxt_pst) ||
    (pst_ff == pairing_ctrl_pkg::pr_high1 && !level_now);

  always_comb begin
    nxt_pst = pst_ff;
    nxt_mode = mode_ff;
    nxt_pairing = pairing_ff;
    nxt_master = master_ff;
    timeout_ev = 1'b0;
    case (pst_ff)
      pairing_ctrl_pkg::pr_idle: begin
        if (pair_low) nxt_pst = pairing_ctrl_pkg::pr_low1;
      end
      pairing_ctrl_pkg::pr_low1: begin
        if (!pair_low) nxt_pst = pairing_ctrl_pkg::pr_idle;
        else if (pair_hold) begin
          nxt_pst = pairing_ctrl_pkg::pr_high1;
          nxt_mode = 2'(pairing_ctrl_pkg::open_acceptor_mode);
          nxt_pairing = 1'b1;
          nxt_master = 1'b0;
        end
      end
      pairing_ctrl_pkg::pr_high1: begin
        // The counter only runs while the pin is high, so a zero count
        // with the pin low is the tail of the first low, not a new low.
        if (pair_low && pair_hold) nxt_pst = pairing_ctrl_pkg::pr_low2;
        else if (pair_low && pcnt_ff != '0)
          nxt_pst = pairing_ctrl_pkg::pr_wait;
        else if (link_up_ff) nxt_pst = pairing_ctrl_pkg::pr_wait;
      end
      pairing_ctrl_pkg::pr_low2: begin
        if (!pair_low) nxt_pst = pairing_ctrl_pkg::pr_wait;
        else if (pair_hold) begin
          nxt_pst = pairing_ctrl_pkg::pr_wait;
          nxt_mode = 2'(pairing_ctrl_pkg::reconnect_initiator_mode);
          nxt_master = 1'b1;
        end
      end
      pairing_ctrl_pkg::pr_wait: begin
        if (link_up_ff) begin
          nxt_pst = pairing_ctrl_pkg::pr_idle;
          nxt_pairing = 1'b0;
        end else if (wait_over) begin
          timeout_ev = 1'b1;
          nxt_pst = pairing_ctrl_pkg::pr_idle;
          nxt_pairing = 1'b0;
        end
      end
      default: nxt_pst = pairing_ctrl_pkg::pr_idle;
    endcase
    if (sw_mode_wr) nxt_mode = sw_mode;
    if (frst_hit) begin
      nxt_pst = pairing_ctrl_pkg::pr_idle;
      nxt_mode = pairing_ctrl_pkg::MODE_RST;
      nxt_pairing = 1'b0;
      nxt_master = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_ff <= pairing_ctrl_pkg::pr_idle;
      pcnt_ff <= '0;
      mode_ff <= pairing_ctrl_pkg::MODE_RST;
      pairing_ff <= 1'b0;
      master_ff <= 1'b0;
    end else begin
      pst_ff <= nxt_pst;
      pcnt_ff <= restart_cnt ? '0 : pcnt_ff + 1'b1;
      mode_ff <= nxt_mode;
      pairing_ff <= nxt_pairing;
      master_ff <= nxt_master;
    end
  end

  // ***************************************************************
  // Link, state and responses
  // ***************************************************************
  logic link_prev_ff;
  logic resp_req_ff;
  logic rsp_valid_ff;
  logic [1:0] rsp_msg_ff;
  logic [1:0] state_ff;
  wire link_rise = link_up_ff && !link_prev_ff;
  wire link_fall = !link_up_ff && link_prev_ff;
  wire rsp_fire = resp_en_ff && !pairing_ff;
  wire [1:0] nxt_state = link_up_ff ? 2'(pairing_ctrl_pkg::st_connect) :
    (pairing_ff || mode_ff != 2'(pairing_ctrl_pkg::idle_command_mode)) ?
    2'(pairing_ctrl_pkg::st_pending) : 2'(pairing_ctrl_pkg::st_standby);
  wire [1:0] nxt_rsp_msg = link_rise ? 2'(pairing_ctrl_pkg::rsp_connect) :
    link_fall ? 2'(pairing_ctrl_pkg::rsp_disconnect) :
    2'(pairing_ctrl_pkg::rsp_ok);
  wire nxt_rsp_valid = rsp_fire && (link_rise || link_fall || resp_req_ff);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_prev_ff <= 1'b0;
      link_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_msg_ff <= 2'(pairing_ctrl_pkg::rsp_ok);
      state_ff <= 2'(pairing_ctrl_pkg::st_standby);
    end else begin
      link_prev_ff <= link_up_ff;
      link_ff <= !link_up_ff;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_msg_ff <= nxt_rsp_msg;
      state_ff <= nxt_state;
    end
  end

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  logic aw_ok_ff;
  logic [3:0] aw_ff;
  logic w_ok_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [1:0] bresp_ff;
  logic [3:0] irq_st_ff;
  logic [3:0] irq_mask_ff;
  logic irq_ff;
  logic factory_ff;
  wire do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
  wire wr_ctrl = do_wr && aw_ff == pairing_ctrl_pkg::ADDR_CTRL;
  wire wr_istat = do_wr && aw_ff == pairing_ctrl_pkg::ADDR_IRQ_STAT;
  wire wr_imask = do_wr && aw_ff == pairing_ctrl_pkg::ADDR_IRQ_MASK;
  wire wr_bad = do_wr && !(wr_ctrl || wr_istat || wr_imask);
  assign sw_mode = wd_ff[pairing_ctrl_pkg::CTRL_MODE_LSB +: 2];
  assign sw_mode_wr = wr_ctrl;
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire [31:0] ctrl_rd = {27'h000_0000, 1'b0, mode_ff, resp_en_ff,
    link_up_ff};
  wire [31:0] stat_rd = {24'h00_0000, pst_ff, master_ff, pairing_ff,
    state_ff, link_ff};
  wire rd_ok = s_axi_araddr == pairing_ctrl_pkg::ADDR_CTRL ||
    s_axi_araddr == pairing_ctrl_pkg::ADDR_STATUS ||
    s_axi_araddr == pairing_ctrl_pkg::ADDR_IRQ_STAT ||
    s_axi_araddr == pairing_ctrl_pkg::ADDR_IRQ_MASK;
  wire [31:0] rd_mux =
    (s_axi_araddr == pairing_ctrl_pkg::ADDR_CTRL) ? ctrl_rd :
    (s_axi_araddr == pairing_ctrl_pkg::ADDR_STATUS) ? stat_rd :
    (s_axi_araddr == pairing_ctrl_pkg::ADDR_IRQ_STAT) ?
      {28'h000_0000, irq_st_ff} :
    (s_axi_araddr == pairing_ctrl_pkg::ADDR_IRQ_MASK) ?
      {28'h000_0000, irq_mask_ff} : 32'h0000_0000;
  wire [3:0] irq_ev = {timeout_ev, link_rise || link_fall,
    mode_ff != nxt_mode, frst_hit};
  // Set wins over a write-one clear in the same cycle.
  wire [3:0] nxt_irq_st = (irq_st_ff &
    ~(wr_istat && ws_ff[0] ? wd_ff[3:0] : 4'h0)) | irq_ev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_ok_ff <= 1'b0;
      aw_ff <= 4'h0;
      w_ok_ff <= 1'b0;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= pairing_ctrl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_ok_ff) begin
        aw_ok_ff <= 1'b1;
        aw_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok_ff) begin
        w_ok_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_bad ? pairing_ctrl_pkg::RESP_SLVERR :
          pairing_ctrl_pkg::RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= pairing_ctrl_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? pairing_ctrl_pkg::RESP_OKAY :
        pairing_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_up_ff <= 1'b0;
      resp_en_ff <= 1'b1;
      resp_req_ff <= 1'b0;
      irq_st_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff <= 1'b0;
      factory_ff <= 1'b0;
    end else begin
      factory_ff <= frst_hit;
      resp_req_ff <= wr_ctrl && wd_ff[pairing_ctrl_pkg::CTRL_RESP_REQ];
      irq_st_ff <= nxt_irq_st;
      irq_ff <= |(nxt_irq_st & irq_mask_ff);
      if (frst_hit) begin
        link_up_ff <= 1'b0;
        resp_en_ff <= 1'b1;
      end else if (wr_ctrl && ws_ff[0]) begin
        link_up_ff <= wd_ff[pairing_ctrl_pkg::CTRL_LINK_UP];
        resp_en_ff <= wd_ff[pairing_ctrl_pkg::CTRL_RESP_EN];
      end
      if (wr_imask && ws_ff[0]) irq_mask_ff <= wd_ff[3:0];
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign link_detect_n = link_ff;
  assign op_mode = mode_ff;
  assign op_state = state_ff;
  assign link_master = master_ff;
  assign resp_valid = rsp_valid_ff;
  assign resp_msg = rsp_msg_ff;
  assign factory_pulse = factory_ff;
  assign irq = irq_ff;
  assign s_axi_awready = s_axi_awvalid && !aw_ok_ff;
  assign s_axi_wready = s_axi_wvalid && !w_ok_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule : pairing_ctrl

// ### testbench/pairing_ctrl_props.sv
// Checker on the ports of the pairing control block.
// Assumes a bind to pairing_ctrl and one clock domain with async reset.
module pairing_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins and status
  input wire logic factory_rst_n,
  input wire logic factory_pulse,
  input wire logic [1:0] op_mode,
  input wire logic [1:0] op_state,
  input wire logic resp_valid,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_pin_held;
    !$past(factory_rst_n, 4) && !$past(factory_rst_n, 8);
  endsequence

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped early");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped early");
  property p_aw_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write taken while response pending");
  property p_b_after_wr;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after_wr: assert property (p_b_after_wr)
    else $error("write response late");
  property p_resp_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("response strobe longer than one cycle");
  property p_state_legal;
    op_state != 2'h3;
  endproperty
  a_state_legal: assert property (p_state_legal)
    else $error("operating state outside the three states");
  property p_factory_hold;
    factory_pulse |-> s_pin_held;
  endproperty
  a_factory_hold: assert property (p_factory_hold)
    else $error("factory restore without a held reset pin");
  property p_factory_mode;
    factory_pulse |-> ##[0:4] op_mode == 2'h0;
  endproperty
  a_factory_mode: assert property (p_factory_mode)
    else $error("factory restore left the mode set");
endmodule : pairing_ctrl_props

bind pairing_ctrl pairing_ctrl_props u_props (.clk(clk), .rst_b(rst_b),
  .factory_rst_n(factory_rst_n), .factory_pulse(factory_pulse),
  .op_mode(op_mode), .op_state(op_state), .resp_valid(resp_valid),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ### testbench/host_pins.sv
// Host side of the module pins: drives the pairing and reset pins.
// Assumes the pins idle high, as with a pull-up on the host board.
module host_pins (
  // Clock
  input wire logic clk,
  // Pins into the device
  output logic pair_req_n,
  output logic factory_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pair_req_n = 1'b1;
    factory_rst_n = 1'b1;
  end
  // One low hold on a pin; full hold times make the run far too long.
  task automatic pulse_low(input bit is_pair, input int cyc);
    @(posedge clk);
    if (is_pair) pair_req_n <= 1'b0;
    else factory_rst_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    pair_req_n <= 1'b1;
    factory_rst_n <= 1'b1;
  endtask : pulse_low
  // Second-unit sequence: low, high, then low again, cyc cycles each.
  task automatic pair_seq(input int cyc);
    @(posedge clk);
    pair_req_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    pair_req_n <= 1'b1;
    repeat (cyc) @(posedge clk);
    pair_req_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    pair_req_n <= 1'b1;
  endtask : pair_seq
endmodule : host_pins

// ### testbench/tb_top.sv
// Self-checking bench for the pairing control block.
// Assumes a 10 MHz clock; long pin holds are beyond the run length.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, pair_req_n, factory_rst_n, link_detect_n, link_master;
  logic resp_valid, factory_pulse, irq, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] op_mode, op_state, resp_msg, bresp, rresp, last_msg;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  int fail_count, n_compared, resp_cnt, fact_cnt;

  pairing_ctrl dut (.clk(clk), .rst_b(rst_b), .pair_req_n(pair_req_n),
    .factory_rst_n(factory_rst_n), .link_detect_n(link_detect_n),
    .op_mode(op_mode), .op_state(op_state), .link_master(link_master),
    .resp_valid(resp_valid), .resp_msg(resp_msg),
    .factory_pulse(factory_pulse), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  host_pins host (.clk(clk), .pair_req_n(pair_req_n),
    .factory_rst_n(factory_rst_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Strobes are counted here so that a one-cycle pulse is never missed.
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      resp_cnt++;
      last_msg = resp_msg;
    end
    if (factory_pulse === 1'b1) fact_cnt++;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) begin
      fail_count++;
      summarize();
    end
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rready <= 1'b0;
    if (n == 50) begin
      fail_count++;
      summarize();
    end
  endtask : axi_read

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    logic [31:0] d;
    chk("link_detect_n", 1, link_detect_n);
    chk("op_mode", pairing_ctrl_pkg::idle_command_mode, op_mode);
    chk("op_state", pairing_ctrl_pkg::st_standby, op_state);
    chk("irq", 0, irq);
    axi_read(pairing_ctrl_pkg::ADDR_CTRL, d);
    chk("ctrl", 32'h0000_0002, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_link;
    logic [31:0] d;
    logic [1:0] r;
    int c0;
    c0 = resp_cnt;
    axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'h0000_0003, r);
    repeat (4) @(posedge clk);
    chk("link_detect_n", 0, link_detect_n);
    chk("op_state", pairing_ctrl_pkg::st_connect, op_state);
    chk("resp count", c0 + 1, resp_cnt);
    chk("resp msg", pairing_ctrl_pkg::rsp_connect, last_msg);
    chk("irq masked", 0, irq);
    axi_read(pairing_ctrl_pkg::ADDR_IRQ_STAT, d);
    chk("irq status", 32'h0000_0004, d);
    axi_write(pairing_ctrl_pkg::ADDR_IRQ_MASK, 32'h0000_0004, r);
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    axi_write(pairing_ctrl_pkg::ADDR_IRQ_STAT, 32'h0000_0004, r);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'h0000_0002, r);
    repeat (4) @(posedge clk);
    chk("link_detect_n", 1, link_detect_n);
    chk("resp msg", pairing_ctrl_pkg::rsp_disconnect, last_msg);
    $display("test link done");
  endtask : t_link
  task automatic t_resp;
    logic [31:0] d;
    pairing_ctrl_pkg::op_state_e exp_st;
    logic [1:0] r;
    int c0;
    c0 = resp_cnt;
    axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'h0000_0001, r);
    axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'h0000_0000, r);
    repeat (4) @(posedge clk);
    chk("silent resp", c0, resp_cnt);
    axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'h0000_0012, r);
    repeat (4) @(posedge clk);
    chk("ok resp", pairing_ctrl_pkg::rsp_ok, last_msg);
    chk("resp count", c0 + 1, resp_cnt);
    for (int m = 3; m >= 0; m--) begin
      axi_write(pairing_ctrl_pkg::ADDR_CTRL, 32'(m * 4 + 2), r);
      repeat (2) @(posedge clk);
      chk("op_mode", 32'(m), op_mode);
      exp_st = (m != 0) ? pairing_ctrl_pkg::st_pending :
        pairing_ctrl_pkg::st_standby;
      chk("op_state", exp_st, op_state);
    end
    axi_write(4'h1, 32'h0000_0000, r);
    chk("bresp", pairing_ctrl_pkg::RESP_SLVERR, r);
    axi_read(4'h2, d);
    chk("rresp", pairing_ctrl_pkg::RESP_SLVERR, rresp);
    chk("rdata unmapped", 0, d);
    $display("test responses done");
  endtask : t_resp
  task automatic t_glitch;
    int c0;
    logic [31:0] d;
    c0 = fact_cnt;
    host.pulse_low(1'b0, 5000);
    host.pulse_low(1'b1, 5000);
    host.pair_seq(5000);
    repeat (5) @(posedge clk);
    chk("factory pulses", c0, fact_cnt);
    chk("op_mode", pairing_ctrl_pkg::idle_command_mode, op_mode);
    chk("link_master", 0, link_master);
    axi_read(pairing_ctrl_pkg::ADDR_STATUS, d);
    chk("status", 32'h0000_0001, d);
    $display("test glitch done");
  endtask : t_glitch

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    {fail_count, n_compared, resp_cnt, fact_cnt} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'hF;
    wdata = 32'h0000_0000;
    last_msg = 2'h0;
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_link();
    t_resp();
    t_glitch();
    summarize();
  end
endmodule : tb_top
